// file: shared/irpu_pkg.sv
// Purpose: constants for the indirect register pointer unit
// Assumes: 8-bit absolute register numbers, 128 local registers
// Notes:   pointer fields sit in bits 9..2 of a special-register word
package irpu_pkg;
  localparam int unsigned REG_NUM_W   = 8;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned PTR_LSB     = 2;
  localparam int unsigned PTR_MSB     = 9;
  localparam int unsigned LOCAL_CNT   = 128;
  localparam logic [7:0]  LOCAL_BASE  = 8'h80;
  localparam logic [7:0]  GLOBAL_ZERO = 8'h00;
  localparam logic [7:0]  PTR_RESET   = 8'h00;
  localparam int unsigned BANK_CNT    = 16;
  localparam int unsigned BANK_LSB    = 4;

  // special-register selector of a move to or from a pointer
  typedef enum logic [1:0] {
    IRPU_SEL_NONE,
    IRPU_SEL_DEST,
    IRPU_SEL_SRCA,
    IRPU_SEL_SRCB
  } irpu_sel_t;

  // instruction classes; all but IRPU_OP_OTHER load all three pointers from fields
  typedef enum logic [2:0] {
    IRPU_OP_OTHER,
    IRPU_OP_MUL,
    IRPU_OP_FLOAT,
    IRPU_OP_DIVIDE,
    IRPU_OP_SET_PTRS,
    IRPU_OP_EMULATE
  } irpu_op_t;
endpackage : irpu_pkg

// file: logic/irpu_pointer_unit.sv
// Purpose: indirect pointers for the operand slots of the register file
// Assumes: one pipeline stage of decode drives the field and move strobes
// Notes:   new pointer values are visible one cycle after the load
`timescale 1ns/1ps
// Function
// - three pointers: destination, first source, second source field.
// - operand field zero addresses the register file through its pointer.
// - special move writes one pointer from source bits 9 to 2.
// - multiply, float, divide and set-pointers load all three from fields.
// - emulate writes all three; destination pointer content unspecified.
// - divide, multiply and float may overwrite pointers.
// - field-loaded pointers include stack-pointer relocation for locals.
// - field-loaded values checked against bank protection in user mode (emulate skips destination); violation raises trap.
// - float or multiply exception loads pointers from operand fields.
// - 128 local registers; relative local addressing wraps within them.
module irpu_pointer_unit #(
  parameter int unsigned LOCALS = irpu_pkg::LOCAL_CNT
) (
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  input  wire logic                          load_valid,
  input  wire irpu_pkg::irpu_op_t            load_op,
  input  wire logic                          load_exception,
  input  wire logic [7:0]                    dest_reg_field,
  input  wire logic [7:0]                    src_a_field,
  input  wire logic [7:0]                    src_b_field,
  input  wire logic [6:0]                    stack_ptr,
  input  wire logic                          user_mode,
  input  wire logic [15:0]                   bank_protect,
  input  wire irpu_pkg::irpu_sel_t           mtsr_sel,
  input  wire logic [31:0]                   mtsr_data,
  input  wire irpu_pkg::irpu_sel_t           mfsr_sel,
  output logic [31:0]                        mfsr_data,
  output logic [7:0]                         dest_addr,
  output logic [7:0]                         src_a_addr,
  output logic [7:0]                         src_b_addr,
  output logic                               prot_trap
);
  // the 7-bit stack pointer fixes the local window, so no other size is served
  if (LOCALS != irpu_pkg::LOCAL_CNT) begin : g_bad_locals
    $error("irpu: only 128 locals supported");
  end

  logic [7:0] dest_operand_pointer_q;
  logic [7:0] first_source_pointer_q;
  logic [7:0] second_source_pointer_q;
  logic [7:0] reloc_c, reloc_a, reloc_b;
  logic       field_load;
  logic       viol;

  // locals are relative to the stack pointer and wrap mod 128
  function automatic logic [7:0] relocate(input logic [7:0] f, input logic [6:0] sp);
    logic [6:0] sum;
    sum = 7'(f[6:0] + sp);
    relocate = f[7] ? {1'b1, sum} : f;
  endfunction : relocate

  function automatic logic bank_denied(input logic [7:0] r, input logic [15:0] bp,
                                       input logic um);
    bank_denied = um && bp[r[7:irpu_pkg::BANK_LSB]];
  endfunction : bank_denied

  assign reloc_c = relocate(dest_reg_field, stack_ptr);
  assign reloc_a = relocate(src_a_field, stack_ptr);
  assign reloc_b = relocate(src_b_field, stack_ptr);

  // exceptions on multiply or float load too, even if the op is not retired
  always_comb begin
    field_load = 1'b0;
    if (load_valid) begin
      unique case (load_op)
        irpu_pkg::IRPU_OP_MUL,
        irpu_pkg::IRPU_OP_FLOAT:    field_load = 1'b1;
        irpu_pkg::IRPU_OP_DIVIDE,
        irpu_pkg::IRPU_OP_SET_PTRS,
        irpu_pkg::IRPU_OP_EMULATE:  field_load = 1'b1;
        irpu_pkg::IRPU_OP_OTHER:    field_load = 1'b0;
        default:                    field_load = 1'b0;
      endcase
    end
  end

  // emulate carries no destination, so its check skips that field
  assign viol = bank_denied(reloc_a, bank_protect, user_mode) ||
                bank_denied(reloc_b, bank_protect, user_mode) ||
                ((load_op != irpu_pkg::IRPU_OP_EMULATE) &&
                 bank_denied(reloc_c, bank_protect, user_mode));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_trap <= 1'b0;
    end else begin
      prot_trap <= field_load && viol;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dest_operand_pointer_q  <= irpu_pkg::PTR_RESET;
      first_source_pointer_q  <= irpu_pkg::PTR_RESET;
      second_source_pointer_q <= irpu_pkg::PTR_RESET;
    end else if (field_load) begin
      dest_operand_pointer_q  <= reloc_c;
      first_source_pointer_q  <= reloc_a;
      second_source_pointer_q <= reloc_b;
    end else begin
      unique case (mtsr_sel)
        irpu_pkg::IRPU_SEL_DEST:
          dest_operand_pointer_q  <= mtsr_data[irpu_pkg::PTR_MSB:irpu_pkg::PTR_LSB];
        irpu_pkg::IRPU_SEL_SRCA:
          first_source_pointer_q  <= mtsr_data[irpu_pkg::PTR_MSB:irpu_pkg::PTR_LSB];
        irpu_pkg::IRPU_SEL_SRCB:
          second_source_pointer_q <= mtsr_data[irpu_pkg::PTR_MSB:irpu_pkg::PTR_LSB];
        irpu_pkg::IRPU_SEL_NONE: ;
      endcase
    end
  end

  // pointer takes effect next cycle; no forwarding of new values
  always_comb begin
    dest_addr  = (dest_reg_field == irpu_pkg::GLOBAL_ZERO) ? dest_operand_pointer_q
                                                           : reloc_c;
    src_a_addr = (src_a_field == irpu_pkg::GLOBAL_ZERO) ? first_source_pointer_q
                                                        : reloc_a;
    src_b_addr = (src_b_field == irpu_pkg::GLOBAL_ZERO) ? second_source_pointer_q
                                                        : reloc_b;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mfsr_data <= 32'h0000_0000;
    end else begin
      unique case (mfsr_sel)
        irpu_pkg::IRPU_SEL_DEST: mfsr_data <= {22'h0, dest_operand_pointer_q, 2'h0};
        irpu_pkg::IRPU_SEL_SRCA: mfsr_data <= {22'h0, first_source_pointer_q, 2'h0};
        irpu_pkg::IRPU_SEL_SRCB: mfsr_data <= {22'h0, second_source_pointer_q, 2'h0};
        irpu_pkg::IRPU_SEL_NONE: mfsr_data <= 32'h0000_0000;
      endcase
    end
  end

  a_move_one_ptr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !field_load && mtsr_sel == irpu_pkg::IRPU_SEL_SRCA |=>
      first_source_pointer_q == $past(mtsr_data[9:2]) &&
      $stable(second_source_pointer_q) && $stable(dest_operand_pointer_q))
    else $error("move to first source pointer wrong");
  a_field_load_all: assert property (@(posedge ref_clk) disable iff (!arst_n)
    field_load && load_op != irpu_pkg::IRPU_OP_EMULATE |=>
      dest_operand_pointer_q == $past(reloc_c) && first_source_pointer_q == $past(reloc_a) &&
      second_source_pointer_q == $past(reloc_b))
    else $error("field load of pointers wrong");
  a_emulate_srcs: assert property (@(posedge ref_clk) disable iff (!arst_n)
    field_load && load_op == irpu_pkg::IRPU_OP_EMULATE |=>
      first_source_pointer_q == $past(reloc_a) && second_source_pointer_q == $past(reloc_b))
    else $error("emulate source pointers wrong");
  a_zero_indirect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    src_a_field == 8'h00 |-> src_a_addr == first_source_pointer_q)
    else $error("field zero not indirect");
  a_local_reloc: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dest_reg_field[7] && dest_reg_field != 8'h00 |->
      dest_addr == {1'b1, 7'(dest_reg_field[6:0] + stack_ptr)})
    else $error("local relocation wrong");
  a_global_direct: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !src_b_field[7] && src_b_field != 8'h00 |-> src_b_addr == src_b_field)
    else $error("global register relocated");
  a_prot_trap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_op == irpu_pkg::IRPU_OP_SET_PTRS && user_mode &&
      bank_protect[reloc_a[7:4]] |=> prot_trap)
    else $error("protection trap missing");
  a_no_false_trap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !user_mode |=> !prot_trap)
    else $error("trap raised in supervisor");
  a_read_back: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mfsr_sel == irpu_pkg::IRPU_SEL_DEST |=>
      mfsr_data == {22'h0, $past(dest_operand_pointer_q), 2'h0})
    else $error("pointer read-back wrong");
  a_mul_exc_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_exception && load_op == irpu_pkg::IRPU_OP_MUL |=>
      first_source_pointer_q == $past(reloc_a))
    else $error("exception did not load pointers");

  a_move_dest: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !field_load && mtsr_sel == irpu_pkg::IRPU_SEL_DEST |=>
      dest_operand_pointer_q == $past(mtsr_data[irpu_pkg::PTR_MSB:irpu_pkg::PTR_LSB]) &&
      $stable(first_source_pointer_q) && $stable(second_source_pointer_q))
    else $error("move to destination pointer wrong");
  a_move_srcb: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !field_load && mtsr_sel == irpu_pkg::IRPU_SEL_SRCB |=>
      second_source_pointer_q == $past(mtsr_data[irpu_pkg::PTR_MSB:irpu_pkg::PTR_LSB]) &&
      $stable(first_source_pointer_q) && $stable(dest_operand_pointer_q))
    else $error("move to second source pointer wrong");
  a_hold_ptrs: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !field_load && mtsr_sel == irpu_pkg::IRPU_SEL_NONE |=> $stable(dest_operand_pointer_q) &&
      $stable(first_source_pointer_q) && $stable(second_source_pointer_q))
    else $error("pointer changed without a load");
  a_load_beats_move: assert property (@(posedge ref_clk) disable iff (!arst_n)
    field_load && mtsr_sel != irpu_pkg::IRPU_SEL_NONE |=>
      first_source_pointer_q == $past(reloc_a) && second_source_pointer_q == $past(reloc_b))
    else $error("move overrode a field load");
  a_dest_indirect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dest_reg_field == irpu_pkg::GLOBAL_ZERO |-> dest_addr == dest_operand_pointer_q)
    else $error("destination field zero not indirect");
  a_srcb_indirect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    src_b_field == irpu_pkg::GLOBAL_ZERO |-> src_b_addr == second_source_pointer_q)
    else $error("second source field zero not indirect");
  a_srca_local: assert property (@(posedge ref_clk) disable iff (!arst_n)
    src_a_field[7] |-> src_a_addr == {1'b1, 7'(src_a_field[6:0] + stack_ptr)})
    else $error("local source wrap wrong");
  a_emul_skip_dest: assert property (@(posedge ref_clk) disable iff (!arst_n)
    field_load && load_op == irpu_pkg::IRPU_OP_EMULATE &&
      !bank_denied(reloc_a, bank_protect, user_mode) &&
      !bank_denied(reloc_b, bank_protect, user_mode) |=> !prot_trap)
    else $error("emulate trapped on its destination");
  a_read_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mfsr_sel == irpu_pkg::IRPU_SEL_NONE |=> mfsr_data == 32'h0000_0000)
    else $error("idle read-back not zero");
  a_float_exc_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_exception && load_op == irpu_pkg::IRPU_OP_FLOAT |=>
      dest_operand_pointer_q == $past(reloc_c) && second_source_pointer_q == $past(reloc_b))
    else $error("float exception did not load pointers");

  c_setip: cover property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_op == irpu_pkg::IRPU_OP_SET_PTRS ##2 src_a_field == 8'h00);
  c_mtsr: cover property (@(posedge ref_clk) disable iff (!arst_n)
    mtsr_sel == irpu_pkg::IRPU_SEL_DEST ##1 mfsr_sel == irpu_pkg::IRPU_SEL_DEST);
  c_trap: cover property (@(posedge ref_clk) disable iff (!arst_n) prot_trap);
  c_emulate: cover property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_op == irpu_pkg::IRPU_OP_EMULATE);
  c_mul_exc: cover property (@(posedge ref_clk) disable iff (!arst_n)
    load_valid && load_exception && load_op == irpu_pkg::IRPU_OP_MUL);
endmodule : irpu_pointer_unit

// file: sim/irpu_pipe_model.sv
// Purpose: decode pipeline model driving the pointer unit
// Assumes: drives change at the falling edge only
// Notes:   idles one cycle after every pointer write
`timescale 1ns/1ps
module irpu_pipe_model (
  input  wire logic           ref_clk,
  output logic                load_valid,
  output irpu_pkg::irpu_op_t  load_op,
  output logic                load_exception,
  output logic [7:0]          dest_reg_field,
  output logic [7:0]          src_a_field,
  output logic [7:0]          src_b_field,
  output logic [6:0]          stack_ptr,
  output logic                user_mode,
  output logic [15:0]         bank_protect,
  output irpu_pkg::irpu_sel_t mtsr_sel,
  output logic [31:0]         mtsr_data,
  output irpu_pkg::irpu_sel_t mfsr_sel
);
  // zero fields so the next cycle dereferences the pointers
  task automatic idle();
    load_valid = 1'b0;
    load_op = irpu_pkg::IRPU_OP_OTHER;
    load_exception = 1'b0;
    {dest_reg_field, src_a_field, src_b_field} = 24'h000000;
    mtsr_sel = irpu_pkg::IRPU_SEL_NONE;
    mfsr_sel = irpu_pkg::IRPU_SEL_NONE;
    mtsr_data = 32'h00000000;
  endtask : idle
  task automatic load(irpu_pkg::irpu_op_t op, logic ex, logic [7:0] d, logic [7:0] a,
                      logic [7:0] b, logic [6:0] sp, logic um, logic [15:0] bp);
    @(negedge ref_clk);
    {load_valid, load_op, load_exception} = {1'b1, op, ex};
    {dest_reg_field, src_a_field, src_b_field} = {d, a, b};
    {stack_ptr, user_mode, bank_protect} = {sp, um, bp};
    @(negedge ref_clk);
    idle();
  endtask : load
  task automatic move_to(irpu_pkg::irpu_sel_t sel, logic [31:0] data);
    @(negedge ref_clk);
    {mtsr_sel, mtsr_data} = {sel, data};
    @(negedge ref_clk);
    idle();
  endtask : move_to
  task automatic move_from(irpu_pkg::irpu_sel_t sel);
    @(negedge ref_clk);
    mfsr_sel = sel;
    @(negedge ref_clk);
    idle();
  endtask : move_from
  // a move landing with a field load is dropped by the unit
  task automatic load_move(irpu_pkg::irpu_op_t op, logic [7:0] a, irpu_pkg::irpu_sel_t sel,
                           logic [31:0] data);
    @(negedge ref_clk);
    {load_valid, load_op, src_a_field} = {1'b1, op, a};
    {mtsr_sel, mtsr_data} = {sel, data};
    @(negedge ref_clk);
    idle();
  endtask : load_move
  initial begin
    {stack_ptr, user_mode, bank_protect} = 24'h000000;
    idle();
  end
endmodule : irpu_pipe_model

// file: sim/tb_top.sv
// Purpose: self-checking bench of the pointer unit
// Assumes: answers right after the taking edge, before the next one
// Notes:   only zero fields are dereferenced
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, arst_n = 1'b0, lv, le, um;
  logic [7:0] df, af, bf, da, aa, ba;
  logic [6:0] sp;
  logic [15:0] bp;
  logic [31:0] md, fd;
  logic pt;
  irpu_pkg::irpu_op_t op;
  irpu_pkg::irpu_sel_t ms, fs;
  int failures = 0, checked = 0;
  always #2 ref_clk = ~ref_clk;
  irpu_pipe_model pm (.ref_clk(ref_clk), .load_valid(lv), .load_op(op), .load_exception(le),
    .dest_reg_field(df), .src_a_field(af), .src_b_field(bf), .stack_ptr(sp), .user_mode(um),
    .bank_protect(bp), .mtsr_sel(ms), .mtsr_data(md), .mfsr_sel(fs));
  irpu_pointer_unit uut (.ref_clk(ref_clk), .arst_n(arst_n), .load_valid(lv), .load_op(op),
    .load_exception(le), .dest_reg_field(df), .src_a_field(af), .src_b_field(bf),
    .stack_ptr(sp), .user_mode(um), .bank_protect(bp), .mtsr_sel(ms), .mtsr_data(md),
    .mfsr_sel(fs), .mfsr_data(fd), .dest_addr(da), .src_a_addr(aa), .src_b_addr(ba),
    .prot_trap(pt));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic ptrs(logic [7:0] d, logic [7:0] a, logic [7:0] b, logic use_d, logic trap);
    #1;
    if (use_d) check("dest_addr", {24'h0, d}, {24'h0, da});
    check("src_a_addr", {24'h0, a}, {24'h0, aa});
    check("src_b_addr", {24'h0, b}, {24'h0, ba});
    check("prot_trap", {31'h0, trap}, {31'h0, pt});
  endtask : ptrs
  // locals wrap within the 128-entry window
  function automatic logic [7:0] rel(logic [7:0] f, logic [6:0] s);
    return f[7] ? {1'b1, f[6:0] + s} : f;
  endfunction : rel
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    irpu_pkg::irpu_op_t ops [4];
    ops = '{irpu_pkg::IRPU_OP_MUL, irpu_pkg::IRPU_OP_FLOAT, irpu_pkg::IRPU_OP_DIVIDE,
            irpu_pkg::IRPU_OP_SET_PTRS};
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) arst_n = 1'b1;
    ptrs(8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    pm.move_to(irpu_pkg::IRPU_SEL_DEST, 32'hffffff5b);
    ptrs(8'hd6, 8'h00, 8'h00, 1'b1, 1'b0);
    pm.move_from(irpu_pkg::IRPU_SEL_DEST);
    #1 check("mfsr_data", 32'h00000358, fd);
    pm.move_to(irpu_pkg::IRPU_SEL_SRCA, 32'h00000204);
    pm.move_to(irpu_pkg::IRPU_SEL_SRCB, 32'hfffffc2b);
    ptrs(8'hd6, 8'h81, 8'h0a, 1'b1, 1'b0);
    $display("test move done");
    for (int i = 0; i < 4; i++) begin
      pm.load(ops[i], i == 1, 8'h03, 8'h85, 8'h86 + i[7:0], 7'h7f - i[6:0], 1'b0,
              16'hffff);
      ptrs(8'h03, rel(8'h85, 7'h7f - i[6:0]), rel(8'h86 + i[7:0], 7'h7f - i[6:0]),
           1'b1, 1'b0);
    end
    pm.move_from(irpu_pkg::IRPU_SEL_SRCB);
    #1 check("mfsr_data", {22'h0, rel(8'h89, 7'h7c), 2'h0}, fd);
    $display("test class loads done");
    pm.load(irpu_pkg::IRPU_OP_MUL, 1'b1, 8'h81, 8'h10, 8'h20, 7'h10, 1'b0,
            16'h0000);
    ptrs(8'h91, 8'h10, 8'h20, 1'b1, 1'b0);
    // destination bank protected, but emulate leaves it out of the check
    pm.load(irpu_pkg::IRPU_OP_EMULATE, 1'b0, 8'h40, 8'h90, 8'h91, 7'h05, 1'b1,
            16'h0010);
    ptrs(8'h00, 8'h95, 8'h96, 1'b0, 1'b0);
    $display("test exception and emulate done");
    pm.load(irpu_pkg::IRPU_OP_SET_PTRS, 1'b0, 8'h03, 8'h52, 8'h04, 7'h00, 1'b1,
            16'h0020);
    ptrs(8'h03, 8'h52, 8'h04, 1'b1, 1'b1);
    @(negedge ref_clk);
    ptrs(8'h03, 8'h52, 8'h04, 1'b1, 1'b0);
    pm.load(irpu_pkg::IRPU_OP_DIVIDE, 1'b0, 8'h03, 8'h85, 8'h04, 7'h0b, 1'b1,
            16'h0200);
    ptrs(8'h03, 8'h90, 8'h04, 1'b1, 1'b1);
    pm.load(irpu_pkg::IRPU_OP_DIVIDE, 1'b0, 8'h03, 8'h85, 8'h04, 7'h0b, 1'b0,
            16'h0200);
    ptrs(8'h03, 8'h90, 8'h04, 1'b1, 1'b0);
    pm.load_move(irpu_pkg::IRPU_OP_SET_PTRS, 8'h07, irpu_pkg::IRPU_SEL_SRCA,
                 32'h000003fc);
    ptrs(8'h00, 8'h07, 8'h00, 1'b1, 1'b0);
    $display("test protection done");
    results();
  end
  // whole run is under 40 cycles, well inside the 5000-cycle limit below
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule : tb_top
